// *** verilog/nfps_cfg.svh ***
`ifndef NFPS_CFG_SVH
`define NFPS_CFG_SVH

// serial word layout
`define NFPS_WORD_W        16
`define NFPS_ADDR_HI       15
`define NFPS_ADDR_LO       14
`define NFPS_ADDR_CTRL     2'h0
`define NFPS_ADDR_FREQ_A   2'h1
`define NFPS_ADDR_FREQ_B   2'h2
`define NFPS_ADDR_PHASE    2'h3
`define NFPS_HALF_W        14
`define NFPS_PHASE_SEL_BIT 13

// control word bit positions
`define NFPS_FULL_WIDTH_BIT 13
`define NFPS_HALF_BIT       12
`define NFPS_FREQ_BIT       11
`define NFPS_PHASE_BIT      10
`define NFPS_SOURCE_BIT     9
`define NFPS_SIGN_EN_BIT    5
`define NFPS_RSVD_HI_BIT    2
`define NFPS_MODE_BIT       1
`define NFPS_RSVD_LO_BIT    0

// datapath sizes and reset values
`define NFPS_FREQ_W        28
`define NFPS_PHASE_W       12
`define NFPS_DAC_W         10
`define NFPS_LUT_AW        4
`define NFPS_FREQ_RST      28'h0000000
`define NFPS_PHASE_RST     12'h000
`define NFPS_DAC_MID       10'h200
`define NFPS_DAC_MID_LOW   10'h1ff

`endif

// *** verilog/nfps_pkg.sv ***
package nfps_pkg;
  `include "nfps_cfg.svh"

  // pairing state of a full-width frequency load
  typedef enum logic [1:0] {
    NFPS_WAIT_LOW  = 2'b01,
    NFPS_WAIT_HIGH = 2'b10
  } nfps_pair_e;

  typedef logic [`NFPS_WORD_W-1:0] nfps_word_t;
endpackage : nfps_pkg

// *** verilog/nfps_link.sv ***
`timescale 1ns/1ps
`include "nfps_cfg.svh"
// word strobe plus the two select pins between host and synthesizer
interface nfps_link;
  logic                    word_valid;
  logic [`NFPS_WORD_W-1:0] word;
  logic                    freq_choice_pin;
  logic                    phase_choice_pin;

  modport host (
    output word_valid,
    output word,
    output freq_choice_pin,
    output phase_choice_pin
  );

  modport dev (
    input word_valid,
    input word,
    input freq_choice_pin,
    input phase_choice_pin
  );
endinterface : nfps_link

// *** verilog/nfps_device.sv ***
`timescale 1ns/1ps
// Functional notes
// - host writes reserved control bits as zero
// - mode one gives triangle, zero sine
// - host clears mode while sign output enabled
// - two 28-bit frequency, two 12-bit phase
// - output frequency follows selected tuning word
// - phase shift is offset over 4096 turns
// - selected offset added to accumulator output
// - source bit picks pins or control bits
// - frequency select zero A, one B
// - phase select zero A, one B
// - select pins sampled on master clock
// - pin change at edge: one cycle uncertainty
// - host keeps pins steady around edge
// - host drives pins defined under bits
// - source may be switched at any time
// - top bits 01/10 load frequency A/B
// - full width: low half, then high
// - half write steered by half bit
// - top bits 11 load phase register
`include "nfps_cfg.svh"
module nfps_device
  import nfps_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  nfps_link.dev                        link,
  output logic [`NFPS_DAC_W-1:0]       dac_word,
  output logic                         active_freq_b,
  output logic                         active_phase_b,
  output logic                         triangle_mode,
  output logic                         sign_output_enable
);

  // tuning and offset storage
  logic [`NFPS_FREQ_W-1:0]  frequency_word_a;
  logic [`NFPS_FREQ_W-1:0]  frequency_word_b;
  logic [`NFPS_PHASE_W-1:0] phase_offset_a;
  logic [`NFPS_PHASE_W-1:0] phase_offset_b;

  // control word fields
  logic                     full_width_write_bit;
  logic                     half_choice_bit;
  logic                     freq_choice_bit;
  logic                     phase_choice_bit;
  logic                     select_source_bit;
  logic                     mode_bit;

  // pairing of full-width loads
  nfps_pair_e               pair_state;
  nfps_pair_e               next_pair_state;
  logic [1:0]               pair_addr;
  logic [`NFPS_HALF_W-1:0]  pair_low;

  // sampled select pins
  logic                     freq_pin_q;
  logic                     phase_pin_q;

  // datapath
  logic [`NFPS_FREQ_W-1:0]  phase_acc;
  logic [`NFPS_PHASE_W-1:0] phase_sum;

  // quarter-wave sine magnitude, sampled mid-step
  function automatic logic [`NFPS_DAC_W-2:0] sine_lookup_table(
    input logic [`NFPS_LUT_AW-1:0] idx
  );
    logic [`NFPS_DAC_W-2:0] v;
    v = 9'h000;
    case (idx)
      4'h0:    v = 9'h019;
      4'h1:    v = 9'h04b;
      4'h2:    v = 9'h07c;
      4'h3:    v = 9'h0ac;
      4'h4:    v = 9'h0da;
      4'h5:    v = 9'h107;
      4'h6:    v = 9'h130;
      4'h7:    v = 9'h157;
      4'h8:    v = 9'h17b;
      4'h9:    v = 9'h19a;
      4'ha:    v = 9'h1b6;
      4'hb:    v = 9'h1ce;
      4'hc:    v = 9'h1e1;
      4'hd:    v = 9'h1f0;
      4'he:    v = 9'h1f9;
      4'hf:    v = 9'h1fe;
      default: v = 9'h000;
    endcase
    return v;
  endfunction : sine_lookup_table

  // word decode
  wire [1:0] w_addr      = link.word[`NFPS_ADDR_HI:`NFPS_ADDR_LO];
  wire       w_ctrl      = link.word_valid && (w_addr == `NFPS_ADDR_CTRL);
  wire       w_freq      = link.word_valid &&
                           ((w_addr == `NFPS_ADDR_FREQ_A) || (w_addr == `NFPS_ADDR_FREQ_B));
  wire       w_phase     = link.word_valid && (w_addr == `NFPS_ADDR_PHASE);
  wire       w_phase_b   = link.word[`NFPS_PHASE_SEL_BIT];
  wire [`NFPS_HALF_W-1:0]  w_half  = link.word[`NFPS_HALF_W-1:0];
  wire [`NFPS_PHASE_W-1:0] w_phval = link.word[`NFPS_PHASE_W-1:0];

  // full-width load completes on a second write to the same address
  wire pair_done  = w_freq && full_width_write_bit &&
                    (pair_state == NFPS_WAIT_HIGH) && (pair_addr == w_addr);
  wire half_write = w_freq && !full_width_write_bit;

  // new value for a frequency register from the current word
  wire [`NFPS_FREQ_W-1:0] cur_freq = (w_addr == `NFPS_ADDR_FREQ_B) ?
                                     frequency_word_b : frequency_word_a;
  wire [`NFPS_FREQ_W-1:0] pair_val = {w_half, pair_low};
  wire [`NFPS_FREQ_W-1:0] half_val = half_choice_bit ?
                                     {w_half, cur_freq[`NFPS_HALF_W-1:0]} :
                                     {cur_freq[`NFPS_FREQ_W-1:`NFPS_HALF_W], w_half};
  wire [`NFPS_FREQ_W-1:0] freq_val = pair_done ? pair_val : half_val;
  wire                    freq_wr  = pair_done || half_write;

  // selection: source bit chooses pins or control bits, switchable any cycle
  wire sel_freq_b  = select_source_bit ? freq_pin_q  : freq_choice_bit;
  wire sel_phase_b = select_source_bit ? phase_pin_q : phase_choice_bit;
  wire [`NFPS_FREQ_W-1:0]  sel_freq  = sel_freq_b  ? frequency_word_b : frequency_word_a;
  wire [`NFPS_PHASE_W-1:0] sel_phase = sel_phase_b ? phase_offset_b   : phase_offset_a;

  // waveform shaping from the offset phase
  wire [`NFPS_PHASE_W-2:0] tri_fold = phase_sum[`NFPS_PHASE_W-1] ?
                                      ~phase_sum[`NFPS_PHASE_W-2:0] :
                                      phase_sum[`NFPS_PHASE_W-2:0];
  wire [`NFPS_DAC_W-1:0]   tri_val  = tri_fold[`NFPS_PHASE_W-2:`NFPS_PHASE_W-1-`NFPS_DAC_W];
  wire [`NFPS_LUT_AW-1:0]  lut_raw  = phase_sum[`NFPS_PHASE_W-3:`NFPS_PHASE_W-2-`NFPS_LUT_AW];
  wire [`NFPS_LUT_AW-1:0]  lut_idx  = phase_sum[`NFPS_PHASE_W-2] ? ~lut_raw : lut_raw;
  wire [`NFPS_DAC_W-2:0]   lut_mag  = sine_lookup_table(lut_idx);
  wire [`NFPS_DAC_W-1:0]   sin_val  = phase_sum[`NFPS_PHASE_W-1] ?
                                      (`NFPS_DAC_MID_LOW - {1'b0, lut_mag}) :
                                      (`NFPS_DAC_MID + {1'b0, lut_mag});
  wire [`NFPS_DAC_W-1:0]   next_dac = mode_bit ? tri_val : sin_val;

  // pairing state: a foreign frequency address or a control word restarts the pair
  always_comb begin
    next_pair_state = pair_state;
    case (pair_state)
      NFPS_WAIT_LOW: begin
        if (w_freq && full_width_write_bit) begin
          next_pair_state = NFPS_WAIT_HIGH;
        end
      end
      NFPS_WAIT_HIGH: begin
        if (w_ctrl || pair_done) begin
          next_pair_state = NFPS_WAIT_LOW;
        end
      end
      default: next_pair_state = NFPS_WAIT_LOW;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pair_state <= NFPS_WAIT_LOW;
      pair_addr  <= `NFPS_ADDR_CTRL;
      pair_low   <= 14'h0000;
    end else begin
      pair_state <= next_pair_state;
      if (w_freq && full_width_write_bit && !pair_done) begin
        pair_addr <= w_addr;
        pair_low  <= w_half;
      end
    end
  end

  // control word; reserved bits are not stored, the host keeps them zero
  always_ff @(posedge clk) begin
    if (rst) begin
      full_width_write_bit <= 1'b0;
      half_choice_bit      <= 1'b0;
      freq_choice_bit      <= 1'b0;
      phase_choice_bit     <= 1'b0;
      select_source_bit    <= 1'b0;
      mode_bit             <= 1'b0;
      sign_output_enable   <= 1'b0;
    end else if (w_ctrl) begin
      full_width_write_bit <= link.word[`NFPS_FULL_WIDTH_BIT];
      half_choice_bit      <= link.word[`NFPS_HALF_BIT];
      freq_choice_bit      <= link.word[`NFPS_FREQ_BIT];
      phase_choice_bit     <= link.word[`NFPS_PHASE_BIT];
      select_source_bit    <= link.word[`NFPS_SOURCE_BIT];
      mode_bit             <= link.word[`NFPS_MODE_BIT];
      sign_output_enable   <= link.word[`NFPS_SIGN_EN_BIT];
    end
  end

  // frequency registers; a sweep should alternate registers to dodge partial updates
  always_ff @(posedge clk) begin
    if (rst) begin
      frequency_word_a <= `NFPS_FREQ_RST;
      frequency_word_b <= `NFPS_FREQ_RST;
    end else if (freq_wr) begin
      if (w_addr == `NFPS_ADDR_FREQ_B) begin
        frequency_word_b <= freq_val;
      end else begin
        frequency_word_a <= freq_val;
      end
    end
  end

  // phase offset registers
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_offset_a <= `NFPS_PHASE_RST;
      phase_offset_b <= `NFPS_PHASE_RST;
    end else if (w_phase) begin
      if (w_phase_b) begin
        phase_offset_b <= w_phval;
      end else begin
        phase_offset_a <= w_phval;
      end
    end
  end

  // pins are taken once per master clock; a change right at that edge may
  // land one cycle early or late, which the host avoids
  always_ff @(posedge clk) begin
    if (rst) begin
      freq_pin_q  <= 1'b0;
      phase_pin_q <= 1'b0;
    end else begin
      freq_pin_q  <= link.freq_choice_pin;
      phase_pin_q <= link.phase_choice_pin;
    end
  end

  // accumulator steps by the tuning word, so f_out = f_clk * word / 2^28
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_acc <= `NFPS_FREQ_RST;
      phase_sum <= `NFPS_PHASE_RST;
    end else begin
      phase_acc <= phase_acc + sel_freq;
      phase_sum <= phase_acc[`NFPS_FREQ_W-1:`NFPS_FREQ_W-`NFPS_PHASE_W] + sel_phase;
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_word       <= `NFPS_DAC_MID;
      active_freq_b  <= 1'b0;
      active_phase_b <= 1'b0;
      triangle_mode  <= 1'b0;
    end else begin
      dac_word       <= next_dac;
      active_freq_b  <= sel_freq_b;
      active_phase_b <= sel_phase_b;
      triangle_mode  <= mode_bit;
    end
  end

endmodule : nfps_device

// *** verilog/nfps_host.sv ***
`timescale 1ns/1ps
`include "nfps_cfg.svh"
// host end: forwards command words and holds the select pins
module nfps_host
  import nfps_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  nfps_link.host                       link,
  input  wire logic                    cmd_valid,
  input  wire logic [`NFPS_WORD_W-1:0] cmd_word,
  input  wire logic                    freq_pin_req,
  input  wire logic                    phase_pin_req,
  output logic                         cmd_ready
);

  // control-word sanitising: reserved bits forced low, mode dropped with sign output
  wire        is_ctrl  = (cmd_word[`NFPS_ADDR_HI:`NFPS_ADDR_LO] == `NFPS_ADDR_CTRL);
  wire        sign_on  = cmd_word[`NFPS_SIGN_EN_BIT];
  nfps_word_t ctrl_fix;

  always_comb begin
    ctrl_fix = cmd_word;
    ctrl_fix[`NFPS_RSVD_HI_BIT] = 1'b0;
    ctrl_fix[`NFPS_RSVD_LO_BIT] = 1'b0;
    if (sign_on) begin
      ctrl_fix[`NFPS_MODE_BIT] = 1'b0;
    end
  end

  wire [`NFPS_WORD_W-1:0] next_word = is_ctrl ? ctrl_fix : cmd_word;

  // one word per cycle; the strobe lasts a single cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      link.word_valid <= 1'b0;
      link.word       <= 16'h0000;
      cmd_ready       <= 1'b0;
    end else begin
      cmd_ready       <= 1'b1;
      link.word_valid <= cmd_valid && cmd_ready;
      if (cmd_valid && cmd_ready) begin
        link.word <= next_word;
      end
    end
  end

  // pins are always driven to a defined level, changed only at our own edge
  always_ff @(posedge clk) begin
    if (rst) begin
      link.freq_choice_pin  <= 1'b0;
      link.phase_choice_pin <= 1'b0;
    end else begin
      link.freq_choice_pin  <= freq_pin_req;
      link.phase_choice_pin <= phase_pin_req;
    end
  end

endmodule : nfps_host

// *** testbench/nfps_chk.sv ***
`timescale 1ns/1ps
`include "nfps_cfg.svh"
// selection and link checks between the host and device ends
module nfps_chk (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    word_valid,
  input wire logic [`NFPS_WORD_W-1:0] word,
  input wire logic                    freq_choice_pin,
  input wire logic                    phase_choice_pin,
  input wire logic                    active_freq_b,
  input wire logic                    active_phase_b,
  input wire logic                    triangle_mode,
  input wire logic                    sign_output_enable
);
  logic src_q;
  logic fbit_q;
  logic pbit_q;
  wire  ctrl = word_valid && word[15:14] == 2'h0;
  // shadow of the selection bits, cleared like the device's copy
  always_ff @(posedge clk) begin
    if (rst) begin
      {src_q, fbit_q, pbit_q} <= 3'h0;
    end else if (ctrl) begin
      {src_q, fbit_q, pbit_q} <= {word[9], word[11], word[10]};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rsvd_bits_zero: assert property (ctrl |-> word[2] == 1'b0 && word[0] == 1'b0)
    else $error("reserved control bits sent nonzero");
  a_mode_sign_excl: assert property (ctrl && word[5] |-> !word[1])
    else $error("mode sent high with sign output enabled");
  a_mode_stored: assert property (ctrl |-> ##2 triangle_mode == $past(word[1], 2))
    else $error("mode bit not stored");
  a_sign_stored: assert property (ctrl |=> sign_output_enable == $past(word[5]))
    else $error("sign enable bit not stored");
  a_pin_freq_sel: assert property ($past(src_q) |-> active_freq_b == $past(freq_choice_pin, 2))
    else $error("frequency pin selection wrong");
  a_pin_phase_sel: assert property ($past(src_q) |-> active_phase_b == $past(phase_choice_pin, 2))
    else $error("phase pin selection wrong");
  a_bit_freq_sel: assert property (!$past(src_q) |-> active_freq_b == $past(fbit_q))
    else $error("frequency bit selection wrong");
  a_bit_phase_sel: assert property (!$past(src_q) |-> active_phase_b == $past(pbit_q))
    else $error("phase bit selection wrong");
endmodule : nfps_chk

// *** testbench/nco_freq_phase_select_tb.sv ***
`timescale 1ns/1ps
`include "nfps_cfg.svh"
module nco_freq_phase_select_tb;
  import nfps_pkg::*;
  logic        clk;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [15:0] cmd_word = 16'h0;
  logic        fpin = 1'b0;
  logic        ppin = 1'b0;
  logic        cmd_ready;
  logic        afb;
  logic        apb;
  logic        tri_m;
  logic        sgn;
  logic [9:0]  dac_word;
  logic [9:0]  sa [16];
  logic [9:0]  sb [16];
  logic [15:0] w;
  logic [15:0] wx;
  int          j;
  int          err_total = 0;
  int          compares = 0;
  nfps_link link ();
  nfps_host i_nfps_host (.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .freq_pin_req(fpin), .phase_pin_req(ppin), .cmd_ready(cmd_ready));
  nfps_device i_nfps_device (.clk(clk), .rst(rst), .link(link), .dac_word(dac_word),
    .active_freq_b(afb), .active_phase_b(apb), .triangle_mode(tri_m), .sign_output_enable(sgn));
  nfps_chk i_nfps_chk (.clk(clk), .rst(rst), .word_valid(link.word_valid), .word(link.word),
    .freq_choice_pin(link.freq_choice_pin), .phase_choice_pin(link.phase_choice_pin),
    .active_freq_b(afb), .active_phase_b(apb), .triangle_mode(tri_m), .sign_output_enable(sgn));
  // free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // the host cleans control words before they reach the link
  function automatic logic [15:0] exp_word(input logic [15:0] v);
    exp_word = v;
    if (v[15:14] == 2'h0) begin
      exp_word[2] = 1'b0;
      exp_word[0] = 1'b0;
      if (v[5]) exp_word[1] = 1'b0;
    end
  endfunction : exp_word
  // triangle level at phase k/16 of a turn: rising half then falling half
  function automatic logic [9:0] tri_exp(input int k);
    tri_exp = (k < 8) ? 10'(k * 128) : 10'(1023 - (k - 8) * 128);
  endfunction : tri_exp
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // holds valid high, so consecutive calls go out back to back
  task automatic send(input logic [15:0] v);
    cmd_valid = 1'b1;
    cmd_word = v;
    @(negedge clk);
    check("link word", exp_word(v), link.word);
  endtask : send
  task automatic stop;
    cmd_valid = 1'b0;
    @(negedge clk);
  endtask : stop
  task automatic cap(output logic [9:0] s [16]);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      s[i] = dac_word;
    end
  endtask : cap
  task automatic final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // cuts a hang short at about fifteen times the expected run
  initial begin
    #40000;
    err_total++;
    final_report();
  end
  initial begin
    void'($urandom(11786));
    repeat (8) @(negedge clk);
    check("dac in reset", 16'h0200, {6'h0, dac_word});
    check("ready in reset", 16'h0, {15'h0, cmd_ready});
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("ready", 16'h1, {15'h0, cmd_ready});
    // control words: corners first, then random, with random pin levels
    for (int n = 0; n < 40; n++) begin
      w = (n == 0) ? 16'h0227 : (n == 1) ? 16'h0e02 : 16'($urandom) & 16'h3fff;
      fpin = 1'($urandom);
      ppin = 1'($urandom);
      send(w);
      stop();
      wx = exp_word(w);
      repeat (3) @(negedge clk);
      check("mode", {15'h0, wx[1]}, {15'h0, tri_m});
      check("sign", {15'h0, w[5]}, {15'h0, sgn});
      check("freq sel", {15'h0, w[9] ? fpin : w[11]}, {15'h0, afb});
      check("phase sel", {15'h0, w[9] ? ppin : w[10]}, {15'h0, apb});
    end
    // full-width pair puts 2^24 into A, period 16; phase B gets a quarter turn
    send(16'h2000);
    send(16'h4000);
    send(16'h4400);
    send(16'hc000);
    send(16'he400);
    stop();
    repeat (4) @(negedge clk);
    cap(sa);
    send(16'h0400);
    stop();
    repeat (14) @(negedge clk);
    cap(sb);
    check("half turn", 16'h1, {15'h0, sa[0] !== sa[8]});
    for (int i = 0; i < 16; i++) begin
      check("phase shift", {6'h0, sa[(i + 4) % 16]}, {6'h0, sb[i]});
    end
    // half writes give B the same word; switching to it keeps the wave
    send(16'h1000);
    send(16'h8400);
    send(16'h0000);
    send(16'h8000);
    send(16'h0800);
    stop();
    repeat (10) @(negedge clk);
    cap(sb);
    for (int i = 0; i < 16; i++) begin
      check("freq b wave", {6'h0, sa[i]}, {6'h0, sb[i]});
    end
    check("freq b sel", 16'h1, {15'h0, afb});
    // triangle mode on the same tuning: folded phase goes to the converter, no sine table
    send(16'h0802);
    stop();
    repeat (4) @(negedge clk);
    cap(sb);
    j = 0;
    for (int i = 0; i < 16; i++) begin
      if (sb[i] == 10'h000) j = i;
    end
    for (int i = 0; i < 16; i++) begin
      check("triangle", {6'h0, tri_exp(i)}, {6'h0, sb[(j + i) % 16]});
    end
    // reset again mid-run: outputs fall back to their reset levels
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check("dac in reset", 16'h0200, {6'h0, dac_word});
    check("mode in reset", 16'h0, {15'h0, tri_m});
    check("freq sel in reset", 16'h0, {15'h0, afb});
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("ready", 16'h1, {15'h0, cmd_ready});
    final_report();
  end
endmodule : nco_freq_phase_select_tb
